// *** verilog/msf_pkg.sv ***
// constants and types shared by the multi-line serial flash pin front end
package msf_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int T_RP_NS = 200;
  localparam int T_CS_NS = 10;
  localparam int RP_RAW = (T_RP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RP_CYCLES = (RP_RAW < 1) ? 1 : RP_RAW;
  localparam int CS_RAW = (T_CS_NS * 1000) / CLK_PERIOD_PS;
  localparam int CS_CYCLES = (CS_RAW < 1) ? 1 : CS_RAW;

  // ==========================================================
  // pin positions
  localparam int PIN_SCK = 0;
  localparam int PIN_CS = 1;
  localparam int PIN_IO = 2;
  // synchronisers start at idle pin levels: chip select high, pulled-up lines 2 and 3 high,
  // so neither a write-protect low nor a reset pin low is seen straight after reset
  localparam logic [5:0] PIN_RESET_VAL = 6'h32;
  localparam int LINE_SI = 0;
  localparam int LINE_SO = 1;
  localparam int LINE_WP = 2;
  localparam int LINE_RST = 3;

  // ==========================================================
  // line widths
  typedef enum logic [1:0] {MSF_W1, MSF_W2, MSF_W4} msf_width_t;
  localparam logic [2:0] STEP_W1 = 3'h1;
  localparam logic [2:0] STEP_W2 = 3'h2;
  localparam logic [2:0] STEP_W4 = 3'h4;
  localparam logic [3:0] OE_W1 = 4'h2;
  localparam logic [3:0] OE_W2 = 4'h3;
  localparam logic [3:0] OE_W4 = 4'hF;
  localparam logic [3:0] OE_NONE = 4'h0;
endpackage

// *** verilog/msf_sync.sv ***
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module msf_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// *** verilog/msf_pins.sv ***
// pin front end of a multi-line serial flash interface
`timescale 1ns/1ps
`default_nettype none
module msf_pins #(
  parameter int RP_CYC = msf_pkg::RP_CYCLES,
  parameter int CS_CYC = msf_pkg::CS_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // flash pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  // configuration bits
  input wire logic quad_enable,
  input wire logic reset_enable,
  input wire logic status_write_disable_bit,
  input wire logic all_nibble_mode,
  input wire logic busy,
  // phase steering from command core
  input wire msf_pkg::msf_width_t phase_width,
  input wire logic phase_ddr,
  input wire logic phase_out,
  input wire logic [7:0] tx_data,
  output logic tx_take,
  // received bytes
  output logic [7:0] instr,
  output logic instr_valid,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  // register write gating
  input wire logic plain_status_write_cmd,
  input wire logic addressed_register_write_cmd,
  input wire logic target_sr1_cr1,
  output logic reg_write_blocked,
  // status
  output logic selected,
  output logic standby,
  output logic write_in_progress,
  output logic hw_reset
);
  import msf_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_INSTR, ST_BODY} msf_state_t;
  localparam int RPW = $clog2(RP_CYC + 1);
  localparam int CSW = $clog2(CS_CYC + 1);

  // ==========================================================
  // reset release and pin synchronisers
  logic rst_q1;
  logic srst_n;
  logic [5:0] pin_s;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_q1 <= 1'b0;
      srst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      srst_n <= rst_q1;
    end
  end

  msf_sync #(.WIDTH(6), .RESET_VAL(PIN_RESET_VAL)) u_sync (
    .mclk(mclk),
    .rst_n(srst_n),
    .d({io_in, cs_n, sck}),
    .q(pin_s)
  );

  // ==========================================================
  // decode
  msf_state_t state;
  msf_width_t cur_width;
  logic sck_s, cs_s, sck_q, cs_q;
  logic [3:0] io_s;
  logic rise, fall, cs_fall, cs_rise, in_frame, capture, launch;
  logic [2:0] bit_cnt, tx_cnt, step;
  logic [3:0] cnt_sum, tx_sum, oe_mask, out_lanes, oe_data, out_data;
  logic [7:0] rx_shift, tx_shift, tx_word, next_rx, next_tx;
  logic byte_done, drove, post_active, reset_pin_active, rp_low, rp_hit;
  logic [CSW-1:0] post_cnt;
  logic [RPW-1:0] rp_cnt;

  assign sck_s = pin_s[PIN_SCK];
  assign cs_s = pin_s[PIN_CS];
  assign io_s = pin_s[PIN_IO +: 4];
  assign rise = sck_s & ~sck_q;
  assign fall = ~sck_s & sck_q;
  assign cs_fall = ~cs_s & cs_q;
  assign cs_rise = cs_s & ~cs_q;
  // chip select high drops the frame at once, whatever the clock does
  assign in_frame = ~cs_s & (state != ST_IDLE);
  // instruction on line 0 unless all-nibble mode
  assign cur_width = (state == ST_INSTR) ?
                     (all_nibble_mode ? MSF_W4 : MSF_W1) : phase_width;
  assign capture = in_frame & ~((state == ST_BODY) & phase_out)
                   & (rise | ((state == ST_BODY) & phase_ddr & fall));
  assign launch = in_frame & (state == ST_BODY) & phase_out
                  & (fall | (phase_ddr & rise));
  assign tx_word = (tx_cnt == 3'h0) ? tx_data : tx_shift;
  assign cnt_sum = {1'b0, bit_cnt} + {1'b0, step};
  assign tx_sum = {1'b0, tx_cnt} + {1'b0, step};
  assign byte_done = cnt_sum[3];

  // lane steering, msb first on every width
  always_comb begin
    step = STEP_W1;
    oe_mask = OE_W1;
    next_rx = {rx_shift[6:0], io_s[LINE_SI]};
    next_tx = {tx_word[6:0], 1'b0};
    out_lanes = {2'b00, tx_word[7], 1'b0};
    unique case (cur_width)
      MSF_W1: begin
        step = STEP_W1;
      end
      MSF_W2: begin
        step = STEP_W2;
        oe_mask = OE_W2;
        next_rx = {rx_shift[5:0], io_s[LINE_SO], io_s[LINE_SI]};
        next_tx = {tx_word[5:0], 2'b00};
        out_lanes = {2'b00, tx_word[7:6]};
      end
      MSF_W4: begin
        step = STEP_W4;
        oe_mask = OE_W4;
        next_rx = {rx_shift[3:0], io_s};
        next_tx = {tx_word[3:0], 4'h0};
        out_lanes = tx_word[7:4];
      end
      default: begin
        step = STEP_W1;
      end
    endcase
  end

  // ==========================================================
  // frame sequencing
  always_ff @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      sck_q <= 1'b0;
      cs_q <= 1'b1;
      state <= ST_IDLE;
    end else begin
      sck_q <= sck_s;
      cs_q <= cs_s;
      if (hw_reset | cs_s) begin
        state <= ST_IDLE;
      end else if (cs_fall) begin
        state <= ST_INSTR;
      end else if (capture & byte_done & (state == ST_INSTR)) begin
        state <= ST_BODY;
      end
    end
  end

  // ==========================================================
  // receive path
  always_ff @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      bit_cnt <= 3'h0;
      rx_shift <= 8'h00;
      instr <= 8'h00;
      instr_valid <= 1'b0;
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      bit_cnt <= in_frame ? (capture ? cnt_sum[2:0] : bit_cnt) : 3'h0;
      if (capture) begin
        rx_shift <= next_rx;
      end
      instr_valid <= capture & byte_done & (state == ST_INSTR);
      rx_valid <= capture & byte_done & (state == ST_BODY);
      if (capture & byte_done & (state == ST_INSTR)) begin
        instr <= next_rx;
      end
      if (capture & byte_done & (state == ST_BODY)) begin
        rx_byte <= next_rx;
      end
    end
  end

  // ==========================================================
  // transmit path; tx_data is taken when a byte starts
  always_ff @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      tx_cnt <= 3'h0;
      tx_shift <= 8'h00;
      tx_take <= 1'b0;
      out_data <= 4'h0;
      oe_data <= OE_NONE;
      drove <= 1'b0;
    end else begin
      tx_cnt <= in_frame ? (launch ? tx_sum[2:0] : tx_cnt) : 3'h0;
      tx_take <= launch & (tx_cnt == 3'h0);
      if (launch) begin
        tx_shift <= next_tx;
        out_data <= out_lanes;
      end
      if (~in_frame | ~phase_out) begin
        oe_data <= OE_NONE;
      end else if (launch) begin
        oe_data <= oe_mask;
      end
      // a new drive wins over the frame-start clear
      if (launch & oe_mask[LINE_RST]) begin
        drove <= 1'b1;
      end else if (cs_fall) begin
        drove <= 1'b0;
      end
    end
  end

  // ==========================================================
  // post-frame data3 drive and reset pin
  assign post_active = (post_cnt != '0);
  assign io_oe = oe_data | {post_active, 3'h0};
  assign io_out = out_data | {post_active, 3'h0};
  assign reset_pin_active = reset_enable & (~quad_enable | cs_s);
  // own high drive must not be mistaken for a released pin going low
  assign rp_low = reset_pin_active & cs_s & ~io_s[LINE_RST] & ~post_active;
  assign rp_hit = rp_low & (rp_cnt == RPW'(RP_CYC - 1));

  always_ff @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      post_cnt <= '0;
      rp_cnt <= '0;
      hw_reset <= 1'b0;
    end else begin
      if (cs_rise & drove) begin
        post_cnt <= CSW'(CS_CYC);
      end else if (post_active & cs_s) begin
        post_cnt <= post_cnt - 1'b1;
      end else if (~cs_s) begin
        post_cnt <= '0;
      end
      if (~rp_low) begin
        rp_cnt <= '0;
      end else if (rp_cnt != RPW'(RP_CYC)) begin
        rp_cnt <= rp_cnt + 1'b1;
      end
      hw_reset <= rp_hit;
    end
  end

  // ==========================================================
  // status and write gating
  always_ff @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      selected <= 1'b0;
      standby <= 1'b0;
      write_in_progress <= 1'b0;
      reg_write_blocked <= 1'b0;
    end else begin
      selected <= ~cs_s;
      standby <= cs_s & ~busy;
      write_in_progress <= busy;
      // quad enable removes the write-protect function entirely
      reg_write_blocked <= status_write_disable_bit & ~quad_enable & ~io_s[LINE_WP]
                           & (plain_status_write_cmd
                              | (addressed_register_write_cmd & target_sr1_cr1));
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!srst_n);

  sequence s_frame_end;
    cs_rise && drove;
  endsequence

  sequence s_post_drive;
    post_active && io_oe[LINE_RST] && io_out[LINE_RST];
  endsequence

  property p_hiz_deselect;
    $past(cs_s) |-> io_oe[2:0] == 3'h0;
  endproperty
  a_hiz_deselect: assert property (p_hiz_deselect) else $error("outputs driven while deselected");

  property p_post_high;
    s_frame_end |=> s_post_drive;
  endproperty
  a_post_high: assert property (p_post_high) else $error("data3 not driven high after frame");

  property p_reset_cause;
    hw_reset |-> $past(rp_low, 1) && $past(cs_s, 2) && reset_enable;
  endproperty
  a_reset_cause: assert property (p_reset_cause) else $error("reset without pin low");

  property p_quad_no_reset;
    quad_enable && !cs_s |=> rp_cnt == '0;
  endproperty
  a_quad_no_reset: assert property (p_quad_no_reset) else $error("reset counted while quad selected");

  property p_idle_until_fall;
    state == ST_IDLE && !cs_fall |=> state == ST_IDLE;
  endproperty
  a_idle_until_fall: assert property (p_idle_until_fall) else $error("decoding without chip select fall");

  property p_instr_rising;
    capture && state == ST_INSTR |-> rise;
  endproperty
  a_instr_rising: assert property (p_instr_rising) else $error("instruction captured on wrong edge");

  property p_sdr_launch;
    launch && !phase_ddr |-> fall;
  endproperty
  a_sdr_launch: assert property (p_sdr_launch) else $error("sdr output launched on rising edge");

  property p_single_so;
    launch && cur_width == MSF_W1 && phase_out |=> io_oe == OE_W1 || !in_frame;
  endproperty
  a_single_so: assert property (p_single_so) else $error("single output not on line 1");

  property p_wp_block;
    status_write_disable_bit && !quad_enable && !io_s[LINE_WP] && plain_status_write_cmd
      |=> reg_write_blocked;
  endproperty
  a_wp_block: assert property (p_wp_block) else $error("protected write not blocked");

  property p_quad_no_wp;
    $past(quad_enable) |-> !reg_write_blocked;
  endproperty
  a_quad_no_wp: assert property (p_quad_no_wp) else $error("write-protect active in quad mode");

  property p_standby;
    cs_s && !busy |=> standby && !write_in_progress;
  endproperty
  a_standby: assert property (p_standby) else $error("standby not shown when idle");
endmodule
`default_nettype wire

// *** tb/msf_host_model.sv ***
// host controller model driving the flash pins
`timescale 1ns/1ps
`default_nettype none
module msf_host_model (
  // clock
  input wire logic mclk,
  // flash pins
  output logic sck,
  output logic cs_n,
  output logic [3:0] io_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe
);
  logic [3:0] drv = 4'hF;
  logic [3:0] en = 4'hC;
  logic tog = 1'b0;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
  end
  // ============================================================
  // pin resolution
  // lines 0 and 1 have no pull-up, so a released line toggles
  always @(posedge mclk) tog <= ~tog;
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      io_in[k] = io_oe[k] ? io_out[k] : en[k] ? drv[k] : (k >= 2) ? 1'b1 : tog;
    end
  end
  // ============================================================
  // pin tasks
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic frame_start();
    @(negedge mclk);
    sck = 1'b0;
    cs_n = 1'b0;
    wait_cyc(8);
  endtask
  task automatic frame_end();
    sck = 1'b0;
    wait_cyc(8);
    cs_n = 1'b1;
    en = 4'hC;
    drv = 4'hF;
    wait_cyc(12);
  endtask
  // one byte on w lines; rd releases the lines so the device can answer
  task automatic shift(input logic [7:0] d, input int w, input logic rd,
                       output logic [7:0] q);
    logic [7:0] sh;
    logic [3:0] m;
    sh = d;
    q = 8'h00;
    m = (w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h1;
    for (int i = 0; i < 8; i += w) begin
      sck = 1'b0;
      drv = (w == 4) ? sh[7:4] : (w == 2) ? {2'b11, sh[7:6]} : {3'b111, sh[7]};
      en = rd ? (4'hC & ~m) : (m | 4'hC);
      wait_cyc(8);
      q = (w == 4) ? {q[3:0], io_in} : (w == 2) ? {q[5:0], io_in[1:0]} : {q[6:0], io_in[1]};
      sck = 1'b1;
      sh = sh << w;
      wait_cyc(8);
    end
  endtask
  // quad double rate byte: each serial clock edge moves one nibble
  task automatic shift_ddr4(input logic [7:0] d, input logic rd, output logic [7:0] q);
    logic [7:0] sh;
    sh = d;
    q = 8'h00;
    for (int i = 0; i < 2; i++) begin
      drv = sh[7:4];
      en = rd ? 4'h0 : 4'hF;
      wait_cyc(4);
      sck = ~sck;
      wait_cyc(8);
      q = {q[3:0], io_in};
      sh = sh << 4;
    end
  endtask
  // write-protect held firm at a level
  task automatic drive_wp(input logic v);
    en[2] = 1'b1;
    drv[2] = v;
  endtask
  task automatic hold_rst(input int n);
    en[3] = 1'b1;
    drv[3] = 1'b0;
    wait_cyc(n);
    drv[3] = 1'b1;
    wait_cyc(12);
  endtask
endmodule
`default_nettype wire

// *** tb/msf_pins_tb.sv ***
// self-checking bench for the serial flash pin front end
`timescale 1ns/1ps
`default_nettype none
module msf_pins_tb;
  import msf_pkg::*;
  logic mclk, rst_n, sck, cs_n;
  logic [3:0] io_in, io_out, io_oe;
  logic quad_enable, reset_enable, status_write_disable_bit, all_nibble_mode, busy;
  msf_width_t phase_width;
  logic phase_ddr, phase_out, tx_take, instr_valid, rx_valid, reg_write_blocked;
  logic [7:0] tx_data, instr, rx_byte;
  logic plain_status_write_cmd, addressed_register_write_cmd, target_sr1_cr1;
  logic selected, standby, write_in_progress, hw_reset;
  logic [7:0] got_instr = 8'h00, got_rx = 8'h00, n_instr = 8'h00, n_hwr = 8'h00;
  logic saw_d3 = 1'b0;
  int failures = 0;
  int n_checks = 0;
  // plain, addressed, target, disable bit, quad, write-protect, expected block
  localparam logic [41:0] GATE = {7'h49, 7'h4A, 7'h40, 7'h4C, 7'h39, 7'h28};

  msf_host_model u_msf_host_model (.mclk(mclk), .sck(sck), .cs_n(cs_n), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe));
  msf_pins #(.RP_CYC(4), .CS_CYC(2)) u_msf_pins (.mclk(mclk), .rst_n(rst_n), .sck(sck),
    .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .quad_enable(quad_enable),
    .reset_enable(reset_enable), .status_write_disable_bit(status_write_disable_bit),
    .all_nibble_mode(all_nibble_mode), .busy(busy), .phase_width(phase_width),
    .phase_ddr(phase_ddr), .phase_out(phase_out), .tx_data(tx_data), .tx_take(tx_take),
    .instr(instr), .instr_valid(instr_valid), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .plain_status_write_cmd(plain_status_write_cmd),
    .addressed_register_write_cmd(addressed_register_write_cmd),
    .target_sr1_cr1(target_sr1_cr1), .reg_write_blocked(reg_write_blocked),
    .selected(selected), .standby(standby), .write_in_progress(write_in_progress),
    .hw_reset(hw_reset));

  always #2.5 mclk = ~mclk;
  // ============================================================
  // pulse catchers
  always @(posedge mclk) begin
    if (instr_valid === 1'b1) got_instr <= instr;
    if (instr_valid === 1'b1) n_instr <= n_instr + 8'h01;
    if (rx_valid === 1'b1) got_rx <= rx_byte;
    if (hw_reset === 1'b1) n_hwr <= n_hwr + 8'h01;
    if (cs_n && io_oe === 4'h8 && io_out[3] === 1'b1) saw_d3 <= 1'b1;
  end
  // ============================================================
  // checking and ending
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100us;
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end
  // ============================================================
  // tests
  initial begin
    logic [7:0] q, n0;
    logic [6:0] g;
    mclk = 1'b0;
    rst_n = 1'b0;
    {quad_enable, reset_enable, status_write_disable_bit, all_nibble_mode, busy} = 5'h00;
    {phase_ddr, phase_out, tx_data} = 10'h000;
    phase_width = MSF_W1;
    {plain_status_write_cmd, addressed_register_write_cmd, target_sr1_cr1} = 3'h0;
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    u_msf_host_model.wait_cyc(6);
    u_msf_host_model.shift(8'h9F, 1, 1'b0, q);
    chk(n_instr, 8'h00, "clocks while deselected");
    $display("deselect test done");
    {phase_out, tx_data} = {1'b1, 8'h3C};
    u_msf_host_model.frame_start();
    u_msf_host_model.shift(8'h9F, 1, 1'b0, q);
    u_msf_host_model.shift(8'h00, 1, 1'b1, q);
    chk(got_instr, 8'h9F, "single instruction");
    chk(q, 8'h3C, "single read");
    u_msf_host_model.frame_end();
    chk({4'h0, io_oe}, 8'h00, "released");
    $display("single test done");
    {phase_out, tx_data} = {1'b0, 8'hA5};
    phase_width = MSF_W2;
    u_msf_host_model.frame_start();
    u_msf_host_model.shift(8'hBB, 1, 1'b0, q);
    u_msf_host_model.shift(8'h4E, 2, 1'b0, q);
    chk(got_rx, 8'h4E, "dual receive");
    phase_out = 1'b1;
    u_msf_host_model.shift(8'h00, 2, 1'b1, q);
    chk(q, 8'hA5, "dual read");
    u_msf_host_model.frame_end();
    $display("dual test done");
    {quad_enable, all_nibble_mode, phase_out, tx_data} = {3'b110, 8'h96};
    phase_width = MSF_W4;
    u_msf_host_model.frame_start();
    u_msf_host_model.shift(8'h6B, 4, 1'b0, q);
    u_msf_host_model.shift(8'hC3, 4, 1'b0, q);
    chk(got_instr, 8'h6B, "nibble instruction");
    chk(got_rx, 8'hC3, "quad receive");
    phase_out = 1'b1;
    u_msf_host_model.shift(8'h00, 4, 1'b1, q);
    chk(q, 8'h96, "quad read");
    u_msf_host_model.frame_end();
    chk({7'h00, saw_d3}, 8'h01, "data3 high after frame");
    $display("quad test done");
    {all_nibble_mode, phase_out} = 2'b00;
    for (int e = 0; e < 2; e++) begin
      reset_enable = e[0];
      n0 = n_hwr;
      u_msf_host_model.hold_rst(20);
      chk(n_hwr - n0, {7'h00, e[0]}, "reset pin");
    end
    $display("reset pin test done");
    for (int i = 0; i < 6; i++) begin
      g = GATE[i*7 +: 7];
      plain_status_write_cmd = g[6];
      addressed_register_write_cmd = g[5];
      target_sr1_cr1 = g[4];
      status_write_disable_bit = g[3];
      quad_enable = g[2];
      u_msf_host_model.drive_wp(g[1]);
      u_msf_host_model.wait_cyc(6);
      chk({7'h00, reg_write_blocked}, {7'h00, g[0]}, "write gating");
    end
    u_msf_host_model.drive_wp(1'b1);
    $display("gating test done");
    busy = 1'b1;
    u_msf_host_model.wait_cyc(6);
    chk({6'h00, write_in_progress, standby}, 8'h02, "busy");
    busy = 1'b0;
    u_msf_host_model.wait_cyc(6);
    chk({6'h00, write_in_progress, standby}, 8'h01, "standby");
    $display("standby test done");
    quad_enable = 1'b1;
    phase_ddr = 1'b1;
    {phase_out, tx_data} = {1'b0, 8'h5A};
    u_msf_host_model.frame_start();
    u_msf_host_model.shift(8'hED, 1, 1'b0, q);
    u_msf_host_model.shift_ddr4(8'hC6, 1'b0, q);
    chk(got_rx, 8'hC6, "ddr receive");
    phase_out = 1'b1;
    u_msf_host_model.shift_ddr4(8'h00, 1'b1, q);
    chk(q, 8'h5A, "ddr read");
    u_msf_host_model.frame_end();
    $display("ddr test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
